// file: ccrc_parser.sv
// modem-side parser of the channel change request with apb registers
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "ccrc_consts.svh"
module ccrc_parser import ccrc_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        msg_valid,
  input  wire logic [7:0]  msg_byte,
  input  wire logic        msg_last,
  output logic             chg_done,
  output logic             chg_need_sync,
  output logic      [7:0]  chg_init_tech,
  output logic      [7:0]  us_chan_id,
  output logic      [31:0] ds_freq
);
  typedef struct packed {
    ccrc_ps_t    ps;
    logic [7:0]  typ;
    logic [7:0]  sub_typ;
    logic [7:0]  outer;
    logic [7:0]  elen;
    logic [7:0]  cnt;
    logic [31:0] acc;
    logic [15:0] s_tid;
    logic        h_us;
    logic [7:0]  s_us;
    logic        h_ds;
    logic        h_freq;
    logic [31:0] s_freq;
    logic        h_mod;
    logic [7:0]  s_mod;
    logic        h_sym;
    logic [7:0]  s_sym;
    logic        h_intl;
    logic [15:0] s_intl;
    logic        h_dsid;
    logic [7:0]  s_dsid;
    logic        h_sync;
    logic [7:0]  s_sync;
    logic        h_init;
    logic [7:0]  s_init;
    logic        e_res;
    logic [15:0] tid;
    logic [7:0]  us_id;
    logic [31:0] freq;
    logic [7:0]  ds_mod;
    logic [7:0]  ds_sym;
    logic [15:0] intl;
    logic [7:0]  ds_id;
    logic        need_sync;
    logic [7:0]  init_tech;
    logic [4:0]  stat;
    logic        en;
    logic        done;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ccrc_st_t;
  ccrc_st_t    st_reg;
  ccrc_st_t    st_next;
  logic [31:0] a_new;
  logic        fin;
  logic        acc_ph;
  logic        wr_ok;
  logic        cmt;
  logic        cmt_us;
  logic        cmt_mod;
  logic        cmt_skip;
  logic        cmt_init;
  logic        cmt_freq;
  logic        res_hit;
  logic        sw_us;
  logic        sw_dspar;

  assign a_new = {st_reg.acc[23:0], msg_byte};

  always_comb begin
    st_next  = st_reg;
    fin      = 1'b0;
    cmt      = 1'b0;
    cmt_us   = 1'b0;
    cmt_mod  = 1'b0;
    cmt_skip = 1'b0;
    cmt_init = 1'b0;
    cmt_freq = 1'b0;
    res_hit  = 1'b0;
    sw_us    = 1'b0;
    sw_dspar = 1'b0;
    st_next.done = 1'b0;
    // one wait state keeps every apb output on a flip-flop
    acc_ph = psel && penable && !st_reg.pready;
    wr_ok  = psel && penable && st_reg.pready && pwrite;
    st_next.pready = acc_ph;
    if (acc_ph) begin
      st_next.pslverr = paddr > `CCRC_OFS_ACT || paddr[1:0] != 2'b00;
      unique case (paddr)
        `CCRC_OFS_CTRL:  st_next.prdata = {31'h0, st_reg.en};
        `CCRC_OFS_STAT:  st_next.prdata = {27'h0, st_reg.stat};
        `CCRC_OFS_TID:   st_next.prdata = {16'h0, st_reg.tid};
        `CCRC_OFS_US:    st_next.prdata = {24'h0, st_reg.us_id};
        `CCRC_OFS_FREQ:  st_next.prdata = st_reg.freq;
        `CCRC_OFS_DSPAR: st_next.prdata = {8'h0, st_reg.ds_id,
                                           st_reg.ds_sym, st_reg.ds_mod};
        `CCRC_OFS_INTL:  st_next.prdata = {16'h0, st_reg.intl};
        `CCRC_OFS_ACT:   st_next.prdata = {23'h0, st_reg.need_sync,
                                           st_reg.init_tech};
        default:         st_next.prdata = 32'h0;
      endcase
    end
    if (wr_ok && !st_reg.pslverr) begin
      unique case (paddr)
        `CCRC_OFS_CTRL:  st_next.en = pwdata[0];
        `CCRC_OFS_STAT:  st_next.stat = st_reg.stat & ~pwdata[4:0];
        `CCRC_OFS_US: begin
          st_next.us_id = pwdata[7:0];
          sw_us = 1'b1;
        end
        `CCRC_OFS_FREQ:  st_next.freq = pwdata;
        `CCRC_OFS_DSPAR: begin
          st_next.ds_mod = pwdata[7:0];
          st_next.ds_sym = pwdata[15:8];
          st_next.ds_id  = pwdata[23:16];
          sw_dspar = 1'b1;
        end
        `CCRC_OFS_INTL:  st_next.intl = pwdata[15:0];
        default: ;
      endcase
    end
    // parser; runs after the clear above so a status set wins
    if (msg_valid && st_reg.en) begin
      unique case (st_reg.ps)
        P_TID_HI: begin
          st_next.s_tid = {msg_byte, 8'h00};
          {st_next.h_us, st_next.h_ds, st_next.h_freq, st_next.h_mod,
           st_next.h_sym, st_next.h_intl, st_next.h_dsid,
           st_next.h_sync, st_next.h_init, st_next.e_res} = 10'h000;
          st_next.ps = P_TID_LO;
        end
        P_TID_LO: begin
          st_next.s_tid[7:0] = msg_byte;
          st_next.ps = P_TYPE;
        end
        P_TYPE: begin
          st_next.typ = msg_byte;
          st_next.ps  = P_LEN;
        end
        P_LEN: begin
          st_next.elen  = msg_byte;
          st_next.cnt   = msg_byte;
          st_next.outer = msg_byte;
          st_next.acc   = 32'h0;
          if (msg_byte == 8'h00) begin
            st_next.ps = P_TYPE;
          end else if (st_reg.typ == `CCRC_T_DS) begin
            st_next.h_ds = 1'b1;
            st_next.ps   = P_SUB_TYPE;
          end else begin
            st_next.ps = P_VAL;
          end
        end
        P_VAL: begin
          // unknown types, privacy elements included, skip by length
          st_next.acc = a_new;
          st_next.cnt = st_reg.cnt - 8'h01;
          if (st_reg.cnt == 8'h01) begin
            st_next.ps = P_TYPE;
            fin = 1'b1;
          end
        end
        P_SUB_TYPE: begin
          st_next.sub_typ = msg_byte;
          st_next.outer   = st_reg.outer - 8'h01;
          st_next.ps = (st_reg.outer == 8'h01) ? P_TYPE : P_SUB_LEN;
        end
        P_SUB_LEN: begin
          st_next.elen  = msg_byte;
          st_next.cnt   = msg_byte;
          st_next.acc   = 32'h0;
          st_next.outer = st_reg.outer - 8'h01;
          if (st_reg.outer == 8'h01) begin
            st_next.ps = P_TYPE;
          end else if (msg_byte == 8'h00) begin
            st_next.ps = P_SUB_TYPE;
          end else begin
            st_next.ps = P_SUB_VAL;
          end
        end
        P_SUB_VAL: begin
          st_next.acc   = a_new;
          st_next.cnt   = st_reg.cnt - 8'h01;
          st_next.outer = st_reg.outer - 8'h01;
          if (st_reg.cnt == 8'h01) begin
            fin = 1'b1;
          end
          if (st_reg.outer == 8'h01) begin
            st_next.ps = P_TYPE;
          end else if (st_reg.cnt == 8'h01) begin
            st_next.ps = P_SUB_TYPE;
          end
        end
      endcase
      // element complete: wrong nonzero length on us, init, freq or intl, or a reserved code, is flagged only
      if (fin && st_reg.ps == P_VAL) begin
        unique case (st_reg.typ)
          `CCRC_T_US: begin
            if (st_reg.elen == 8'h01) begin
              st_next.h_us = 1'b1;
              st_next.s_us = msg_byte;
            end else begin
              res_hit = 1'b1;
            end
          end
          `CCRC_T_INIT: begin
            if (st_reg.elen == 8'h01 && msg_byte <= `CCRC_INIT_MAX) begin
              st_next.h_init = 1'b1;
              st_next.s_init = msg_byte;
            end else begin
              res_hit = 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (fin && st_reg.ps == P_SUB_VAL) begin
        unique case (st_reg.sub_typ)
          `CCRC_S_FREQ: begin
            st_next.h_freq = st_reg.elen == 8'h04;
            st_next.s_freq = a_new;
            res_hit = st_reg.elen != 8'h04;
          end
          `CCRC_S_MOD: begin
            st_next.h_mod = msg_byte <= `CCRC_MOD_MAX;
            st_next.s_mod = msg_byte;
            res_hit = msg_byte > `CCRC_MOD_MAX;
          end
          `CCRC_S_SYM: begin
            st_next.h_sym = msg_byte <= `CCRC_SYM_MAX;
            st_next.s_sym = msg_byte;
            res_hit = msg_byte > `CCRC_SYM_MAX;
          end
          `CCRC_S_INTL: begin
            // first byte is I, second is J
            st_next.h_intl = st_reg.elen == 8'h02;
            st_next.s_intl = {a_new[7:0], a_new[15:8]};
            res_hit = st_reg.elen != 8'h02;
          end
          `CCRC_S_DSID: begin
            st_next.h_dsid = 1'b1;
            st_next.s_dsid = msg_byte;
          end
          `CCRC_S_SYNC: begin
            st_next.h_sync = msg_byte <= `CCRC_SYNC_MAX;
            st_next.s_sync = msg_byte;
            res_hit = msg_byte > `CCRC_SYNC_MAX;
          end
          default: ;
        endcase
      end
      if (res_hit) begin
        st_next.e_res = 1'b1;
        st_next.stat[`CCRC_ST_RES] = 1'b1;
      end
      if (msg_last) begin
        if (st_next.ps != P_TYPE || st_reg.ps == P_TID_HI) begin
          // a cut message commits no field; the trunc status bit is set in place of done
          st_next.stat[`CCRC_ST_TRUNC] = 1'b1;
        end else begin
          cmt      = 1'b1;
          cmt_us   = st_next.h_us;
          cmt_mod  = st_next.h_mod;
          cmt_skip = st_next.h_sync && st_next.s_sync == `CCRC_SYNC_SKIP;
          cmt_init = st_next.h_init;
          cmt_freq = st_next.h_freq && st_next.s_freq % `CCRC_FREQ_STEP == '0;
          st_next.done = 1'b1;
          st_next.stat[`CCRC_ST_DONE] = 1'b1;
          st_next.tid = st_next.s_tid;
          // only fields carried by the request are replaced, except need_sync and init_tech, which fall back to defaults
          st_next.us_id = cmt_us ? st_next.s_us : st_next.us_id;
          if (cmt_freq) begin
            st_next.freq = st_next.s_freq;
          end else if (st_next.h_freq) begin
            st_next.stat[`CCRC_ST_FREQ] = 1'b1;
          end
          if (st_next.h_ds && !st_next.h_freq) begin
            st_next.stat[`CCRC_ST_NOFREQ] = 1'b1;
          end
          st_next.ds_mod = cmt_mod ? st_next.s_mod : st_next.ds_mod;
          if (st_next.h_sym) begin
            st_next.ds_sym = st_next.s_sym;
          end
          if (st_next.h_intl) begin
            st_next.intl = st_next.s_intl;
          end
          if (st_next.h_dsid) begin
            st_next.ds_id = st_next.s_dsid;
          end
          st_next.need_sync = !cmt_skip;
          st_next.init_tech = cmt_init ? st_next.s_init
                                       : `CCRC_INIT_FULL;
        end
        st_next.ps = P_TID_HI;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign prdata        = st_reg.prdata;
  assign pready        = st_reg.pready;
  assign pslverr       = st_reg.pslverr;
  assign chg_done      = st_reg.done;
  assign chg_need_sync = st_reg.need_sync;
  assign chg_init_tech = st_reg.init_tech;
  assign us_chan_id    = st_reg.us_id;
  assign ds_freq       = st_reg.freq;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_us_keep_id: assert property (
    ce && cmt && !cmt_us && !sw_us |=> $stable(us_chan_id))
    else $error("upstream id changed without element");
  a_us_take_id: assert property (
    ce && cmt && cmt_us |=> us_chan_id == $past(st_next.s_us))
    else $error("upstream id not taken");
  a_sync_wait: assert property (
    ce && cmt && !cmt_skip |=> chg_need_sync && chg_done)
    else $error("sync wait not requested");
  a_sync_skip: assert property (
    ce && cmt && cmt_skip |=> !chg_need_sync)
    else $error("sync wait not skipped");
  a_init_full: assert property (
    ce && cmt && !cmt_init |=> chg_init_tech == `CCRC_INIT_FULL)
    else $error("missing init element not full reinit");
  a_mod_keep: assert property (
    ce && cmt && !cmt_mod && !sw_dspar |=> $stable(st_reg.ds_mod))
    else $error("modulation changed without element");
  a_res_flag: assert property (
    ce && res_hit |=> st_reg.stat[`CCRC_ST_RES] && st_reg.e_res)
    else $error("reserved code not flagged");
  a_freq_take: assert property (
    ce && cmt && cmt_freq |=> ds_freq == $past(st_next.s_freq)
      && ds_freq % `CCRC_FREQ_STEP == 32'h0)
    else $error("frequency not applied");
  a_init_legal: assert property (
    chg_done |-> chg_init_tech <= `CCRC_INIT_MAX)
    else $error("init technique out of range");
  a_apb_wait: assert property (
    ce && psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer late");
  c_commit: cover property (ce && cmt && cmt_us && cmt_freq);
  c_skip: cover property (ce && cmt && cmt_skip);
  c_reserved: cover property (ce && res_hit);
  c_apb_read: cover property (psel && penable && pready && !pwrite);
endmodule

// file: ccrc_consts.svh
// constants of the channel change request codec
`ifndef CCRC_CONSTS_SVH
`define CCRC_CONSTS_SVH
`define CCRC_OFS_CTRL    8'h00
`define CCRC_OFS_STAT    8'h04
`define CCRC_OFS_TID     8'h08
`define CCRC_OFS_US      8'h0c
`define CCRC_OFS_FREQ    8'h10
`define CCRC_OFS_DSPAR   8'h14
`define CCRC_OFS_INTL    8'h18
`define CCRC_OFS_ACT     8'h1c
`define CCRC_ST_DONE     0
`define CCRC_ST_RES      1
`define CCRC_ST_FREQ     2
`define CCRC_ST_NOFREQ   3
`define CCRC_ST_TRUNC    4
`define CCRC_T_US        8'h01
`define CCRC_T_DS        8'h02
`define CCRC_T_INIT      8'h03
`define CCRC_S_FREQ      8'h01
`define CCRC_S_MOD       8'h02
`define CCRC_S_SYM       8'h03
`define CCRC_S_INTL      8'h04
`define CCRC_S_DSID      8'h05
`define CCRC_S_SYNC      8'h06
`define CCRC_MOD_MAX     8'h01
`define CCRC_SYM_MAX     8'h02
`define CCRC_SYNC_MAX    8'h01
`define CCRC_INIT_MAX    8'h04
`define CCRC_SYNC_SKIP   8'h01
`define CCRC_INIT_FULL   8'h00
`define CCRC_FREQ_STEP   32'd62500
`endif

// file: ccrc_pkg.sv
// types of the channel change request codec
package ccrc_pkg;
  typedef enum logic [2:0] {
    P_TID_HI, P_TID_LO, P_TYPE, P_LEN, P_VAL,
    P_SUB_TYPE, P_SUB_LEN, P_SUB_VAL
  } ccrc_ps_t;
endpackage

// file: ccrc_hec_model.sv
// headend controller model that streams request bytes to the parser
`timescale 1ns/100ps
module ccrc_hec_model (
  input  wire logic       pclk,
  output logic            msg_valid,
  output logic      [7:0] msg_byte,
  output logic            msg_last
);
  initial begin
    msg_valid = 1'b0;
    msg_byte  = 8'h00;
    msg_last  = 1'b0;
  end

  // id leads every request; callers build bodies that keep headend rules
  // privacy elements come from the caller, the digest always placed last
  task automatic send(input logic [15:0] tid, input logic [7:0] body[$]);
    logic [7:0] q[$];
    q = {tid[15:8], tid[7:0], body};
    foreach (q[i]) begin
      @(posedge pclk);
      msg_valid <= 1'b1;
      msg_byte  <= q[i];
      msg_last  <= (i == q.size() - 1);
    end
    @(posedge pclk);
    msg_valid <= 1'b0;
    msg_last  <= 1'b0;
    // released line shows the inverse, not a stale copy
    msg_byte  <= ~q[q.size() - 1];
  endtask
endmodule

// file: tb_top.sv
// self-checking bench of the channel change request parser
`timescale 1ns/100ps
`include "ccrc_consts.svh"
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        msg_valid;
  logic [7:0]  msg_byte;
  logic        msg_last;
  logic        chg_done;
  logic        chg_need_sync;
  logic [7:0]  chg_init_tech;
  logic [7:0]  us_chan_id;
  logic [31:0] ds_freq;
  logic [31:0] rv;
  logic        er;
  int          n_fail;
  int          checks;
  // element codes of the privacy pair; values are arbitrary here
  localparam logic [7:0] key_seq_type = 8'hf0;
  localparam logic [7:0] digest_type  = 8'hf1;

  ccrc_parser u_ccrc_parser (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_valid(msg_valid), .msg_byte(msg_byte), .msg_last(msg_last),
    .chg_done(chg_done), .chg_need_sync(chg_need_sync),
    .chg_init_tech(chg_init_tech), .us_chan_id(us_chan_id),
    .ds_freq(ds_freq)
  );

  ccrc_hec_model u_ccrc_hec_model (
    .pclk(pclk), .msg_valid(msg_valid), .msg_byte(msg_byte),
    .msg_last(msg_last)
  );

  always #25 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // one wait state is promised; only the watchdog ends a hang
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 32'h2, "apb wait states");
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic msg(input logic [15:0] tid, input logic [7:0] b[$],
                     input logic done);
    u_ccrc_hec_model.send(tid, b);
    #1;
    chk({31'b0, chg_done}, {31'b0, done}, "done pulse");
    @(posedge pclk);
    #1;
    chk({31'b0, chg_done}, 32'h0, "done width");
  endtask

  task automatic t_regs();
    chk(ds_freq, 32'h0, "reset freq");
    apb(1'b0, `CCRC_OFS_ACT, 32'h0);
    chk(rv, 32'h0, "reset act");
    apb(1'b1, `CCRC_OFS_US, 32'h05);
    apb(1'b0, `CCRC_OFS_US, 32'h0);
    chk(rv, 32'h05, "us seed");
    apb(1'b1, `CCRC_OFS_TID, 32'hffff);
    apb(1'b0, `CCRC_OFS_TID, 32'h0);
    chk(rv, 32'h0, "tid read only");
    apb(1'b0, 8'h20, 32'h0);
    chk({31'b0, er}, 32'h1, "unmapped err");
    apb(1'b0, 8'h02, 32'h0);
    chk({31'b0, er}, 32'h1, "unaligned err");
    apb(1'b1, `CCRC_OFS_CTRL, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_walk();
    // new upstream id 7 differs from the seeded 5
    msg(16'h1234, '{8'h01, 8'h01, 8'h07}, 1'b1);
    chk({24'h0, us_chan_id}, 32'h07, "us id");
    chk({31'b0, chg_need_sync}, 32'h1, "sync wait");
    chk({24'h0, chg_init_tech}, 32'h0, "init full");
    chk(ds_freq, 32'h0, "ds kept");
    apb(1'b0, `CCRC_OFS_TID, 32'h0);
    chk(rv, 32'h1234, "tid");
    // a low clock enable freezes the parser, so these bytes are lost
    ce <= 1'b0;
    msg(16'h5555, '{8'h01, 8'h01, 8'h09}, 1'b0);
    chk({24'h0, us_chan_id}, 32'h07, "frozen us");
    @(posedge pclk);
    ce <= 1'b1;
    $display("test walk done");
  endtask

  task automatic t_ds();
    // sub 9, association, flow and privacy elements are skipped by length
    msg(16'h00ab, '{8'h02, 8'h1a, 8'h01, 8'h04, 8'h23, 8'hc3, 8'h46,
        8'h00, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01, 8'h02, 8'h04, 8'h02,
        8'h08, 8'h10, 8'h05, 8'h01, 8'h2a, 8'h06, 8'h01, 8'h01,
        8'h09, 8'h02, 8'haa, 8'hbb, 8'h03, 8'h01, 8'h04,
        8'h06, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02,
        8'h07, 8'h02, 8'h01, 8'h02, 8'h07, 8'h02, 8'h03, 8'h04,
        key_seq_type, 8'h01, 8'h05,
        digest_type, 8'h02, 8'hc4, 8'h5e}, 1'b1);
    chk(ds_freq, 32'h23c34600, "freq");
    chk({24'h0, us_chan_id}, 32'h07, "us kept");
    chk({31'b0, chg_need_sync}, 32'h0, "sync skip");
    chk({24'h0, chg_init_tech}, 32'h04, "init 4");
    apb(1'b0, `CCRC_OFS_DSPAR, 32'h0);
    chk(rv, 32'h002a0201, "dspar");
    apb(1'b0, `CCRC_OFS_INTL, 32'h0);
    chk(rv, 32'h1008, "intl");
    apb(1'b0, `CCRC_OFS_ACT, 32'h0);
    chk(rv, 32'h004, "act");
    $display("test downstream done");
  endtask

  task automatic t_bad();
    apb(1'b1, `CCRC_OFS_STAT, 32'h1f);
    // frequency off grid sets the frequency flag, modulation code 2 is a reserved case
    msg(16'h0002, '{8'h02, 8'h09, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00,
        8'h01, 8'h02, 8'h01, 8'h02}, 1'b1);
    chk(ds_freq, 32'h23c34600, "freq kept");
    apb(1'b0, `CCRC_OFS_STAT, 32'h0);
    chk(rv & 32'h6, 32'h6, "stat flags");
    apb(1'b0, `CCRC_OFS_DSPAR, 32'h0);
    chk(rv, 32'h002a0201, "mod kept");
    chk({31'b0, chg_need_sync}, 32'h1, "sync wait");
    chk({24'h0, chg_init_tech}, 32'h0, "init full");
    apb(1'b1, `CCRC_OFS_STAT, 32'h1f);
    msg(16'h0003, '{8'h01, 8'h01}, 1'b0);
    chk({24'h0, us_chan_id}, 32'h07, "trunc kept");
    apb(1'b0, `CCRC_OFS_STAT, 32'h0);
    chk(rv & 32'h10, 32'h10, "trunc flag");
    $display("test reserved done");
  endtask

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    n_fail  = 0;
    checks  = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_walk();
    t_ds();
    t_bad();
    end_of_test();
  end

  // about 40000 cycles, far beyond the few hundred the tests need
  initial begin
    #2000000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
